// >>> rtl/sac_pkg.sv
// Constants shared by the SAR converter control block
package sac_pkg;
    // Register indices: byte address is four times the index
    localparam logic [6:0] IDX_WAKE = 7'h10;
    localparam logic [6:0] IDX_FLAGS = 7'h15;
    localparam logic [6:0] IDX_MASK = 7'h1B;
    localparam logic [6:0] IDX_CTRL = 7'h3E;
    localparam logic [6:0] IDX_REF = 7'h3F;
    localparam logic [6:0] IDX_CHAN = 7'h40;
    localparam logic [6:0] IDX_PINL = 7'h41;
    localparam logic [6:0] IDX_PINH = 7'h42;
    localparam logic [6:0] IDX_RESL = 7'h43;
    localparam logic [6:0] IDX_RESH = 7'h44;
    localparam logic [6:0] IDX_AUXL = 7'h45;
    localparam logic [6:0] IDX_AUXH = 7'h46;
    // Field positions
    localparam int CTRL_CLK_LSB = 5;
    localparam int CTRL_GO_BIT = 4;
    localparam int CTRL_PWR_BIT = 3;
    localparam int CTRL_SHS_LSB = 0;
    localparam int REF_PIN_BIT = 1;
    localparam int REF_LVL_LSB = 2;
    localparam int EVT_BIT = 4;
    // Writable bits of the masked registers, and the common reset value
    localparam logic [7:0] REF_MASK = 8'h3E;
    localparam logic [7:0] CHAN_MASK = 8'h1F;
    localparam logic [7:0] PINH_MASK = 8'h7F;
    localparam logic [7:0] EVT_MASK = 8'h10;
    localparam logic [7:0] RST_VAL = 8'h00;
    // Converter timing in converter clock periods, trial bits and fixed selector and vector codes
    localparam logic [4:0] SAMPLE_TAD_SHS10 = 5'h08;
    localparam logic [3:0] CONV_TOP_BIT = 4'hB;
    localparam logic [11:0] SAR_FIRST = 12'h800;
    localparam logic [2:0] CLK_SEL_SUB = 3'h7;
    localparam logic [4:0] QUARTER_CHAN = 5'h1F;
    localparam logic [7:0] IRQ_VECTOR = 8'h10;
    typedef enum logic [1:0] {
        SAC_IDLE = 2'h0,
        SAC_LEAD = 2'h1,
        SAC_SAMPLE = 2'h3,
        SAC_CONV = 2'h2
    } sac_state_t;
endpackage

// >>> rtl/sac_prescaler.sv
// Converter clock period generator
`timescale 1ns/1ns
module sac_prescaler (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic restart,
    input wire logic [2:0] div_sel,
    input wire logic green_mode,
    input wire logic sub_clk_tick,
    output logic tad_tick
);
    function automatic logic [6:0] div_of(input logic [2:0] sel);
        unique case (sel)
            3'h0: div_of = 7'h10;
            3'h1: div_of = 7'h08;
            3'h2: div_of = 7'h04;
            3'h3: div_of = 7'h02;
            3'h4: div_of = 7'h40;
            3'h5: div_of = 7'h20;
            3'h6: div_of = 7'h01;
            3'h7: div_of = 7'h01;
        endcase
    endfunction

    logic [6:0] div;
    logic [6:0] cnt_q;
    logic use_sub;
    logic wrap;

    assign use_sub = green_mode | (div_sel == sac_pkg::CLK_SEL_SUB);
    assign div = div_of(div_sel);
    assign wrap = (cnt_q >= div - 7'h01);

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            cnt_q <= 7'h00;
        end else if (restart) begin
            // First period ends half a period after the start at ratios 2 to 64, a full period at ratio 1
            cnt_q <= {1'b0, div[6:1]};
        end else if (wrap) begin
            cnt_q <= 7'h00;
        end else begin
            cnt_q <= cnt_q + 7'h01;
        end
    end

    assign tad_tick = ~restart & (use_sub ? sub_clk_tick : wrap);
endmodule

// >>> rtl/sac_sar_seq.sv
// Sample, hold and bit-trial sequencer
`timescale 1ns/1ns
module sac_sar_seq (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic start,
    input wire logic abort,
    input wire logic tad_tick,
    input wire logic [1:0] sample_sel,
    input wire logic cmp_high,
    output logic sample_hold,
    output logic busy,
    output logic done,
    output logic [11:0] code
);
    sac_pkg::sac_state_t state_q;
    logic [4:0] cnt_q;
    logic [3:0] bit_q;
    logic [4:0] len;
    logic last;

    // hold length, eight periods for code 10
    assign len = (sample_sel == 2'h2) ? sac_pkg::SAMPLE_TAD_SHS10
               : (5'h02 << sample_sel);
    assign last = tad_tick & (bit_q == 4'h0);

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            state_q <= sac_pkg::SAC_IDLE;
        end else if (abort) begin
            state_q <= sac_pkg::SAC_IDLE;
        end else begin
            unique case (state_q)
                sac_pkg::SAC_IDLE: if (start) begin
                    state_q <= sac_pkg::SAC_LEAD;
                end
                sac_pkg::SAC_LEAD: if (tad_tick) begin
                    state_q <= sac_pkg::SAC_SAMPLE;
                end
                sac_pkg::SAC_SAMPLE:
                    if (tad_tick && cnt_q == len - 5'h01) begin
                        state_q <= sac_pkg::SAC_CONV;
                    end
                sac_pkg::SAC_CONV: if (last) begin
                    state_q <= sac_pkg::SAC_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            cnt_q <= 5'h00;
        end else if (state_q != sac_pkg::SAC_SAMPLE) begin
            cnt_q <= 5'h00;
        end else if (tad_tick) begin
            cnt_q <= cnt_q + 5'h01;
        end
    end

    // twelve bit trials, most significant first
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            code <= 12'h000;
            bit_q <= 4'h0;
        end else if (state_q == sac_pkg::SAC_SAMPLE) begin
            code <= sac_pkg::SAR_FIRST;
            bit_q <= sac_pkg::CONV_TOP_BIT;
        end else if (state_q == sac_pkg::SAC_CONV && tad_tick) begin
            code[bit_q] <= cmp_high;
            if (bit_q != 4'h0) begin
                code[4'(bit_q - 4'h1)] <= 1'b1;
                bit_q <= 4'(bit_q - 4'h1);
            end
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            done <= 1'b0;
        end else begin
            done <= (state_q == sac_pkg::SAC_CONV) & last & ~abort;
        end
    end

    assign sample_hold = (state_q == sac_pkg::SAC_SAMPLE);
    assign busy = (state_q != sac_pkg::SAC_IDLE);
endmodule

// >>> rtl/sac_top.sv
// SAR converter control: registers, clocking, sequencing, wake
//
// Behaviour
// - Completed 12-bit code loads result registers
// - High holds bits 11..8, low 7..0
// - Completion sets done flag; interrupt request if enabled
// - Positive reference from pin bit, level field
// - Clock select picks main ratio or sub
// - Half-period lead, 2, 4, 8 or 16 sample, 12 conversion periods; the lead is half a period only at ratios 2 to 64
// - Conversion keeps running while core sleeps
// - Run bit clears itself at completion
// - Wake if enabled, else power converter off
// - Wake without global enable resumes next instruction
// - Wake with global enable takes vector 10
// - Done flag sets regardless of mask, global
// - Channel change on readout may clear results
// - Quarter-supply channel enables divider, others disconnect
//
// Our own choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ns
module sac_top (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [8:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic core_sleep,
    input wire logic green_mode,
    input wire logic global_int_on,
    input wire logic sub_clk_tick,
    input wire logic cmp_high,
    output logic sample_hold,
    output logic [11:0] sar_code,
    output logic conv_busy,
    output logic converter_power_on,
    output logic pos_ref_pin_select,
    output logic [1:0] internal_ref_level_select,
    output logic [4:0] input_channel_select,
    output logic [14:0] analog_pin_enables,
    output logic quarter_div_enable,
    output logic conv_wake,
    output logic conv_irq_req,
    output logic conv_vector_req,
    output logic [7:0] conv_irq_vector
);
    logic ack_q;
    logic req;
    logic [6:0] idx;
    logic wr_ok;
    logic [7:0] wd;
    logic [31:0] rdata_q;

    logic [7:0] ctrl_q;
    logic [7:0] ref_q;
    logic [7:0] chan_q;
    logic [7:0] pinl_q;
    logic [7:0] pinh_q;
    logic [7:0] resl_q;
    logic [7:0] resh_q;
    logic [7:0] auxl_q;
    logic [7:0] auxh_q;
    logic wake_en_q;
    logic flag_q;
    logic irq_en_q;
    logic go_q;
    logic shut_q;
    logic wake_q;

    logic wr_ctrl;
    logic wd_go;
    logic wd_pwr;
    logic start;
    logic abort;
    logic tad_tick;
    logic done;
    logic [11:0] code;
    logic seq_busy;

    function automatic logic hit(
        input logic ok,
        input logic [6:0] a,
        input logic [6:0] t
    );
        hit = ok & (a == t);
    endfunction

    // Bus slave: one wait state on every access
    assign req = avs_read | avs_write;
    assign avs_waitrequest = req & ~ack_q;
    assign idx = avs_address[8:2];
    assign wd = avs_writedata[7:0];
    assign wr_ok = avs_write & ack_q & avs_byteenable[0]
                 & (avs_address[1:0] == 2'h0);

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req & ~ack_q;
        end
    end

    // Read data sampled in the wait cycle, held for the accept edge
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            rdata_q <= 32'h0000_0000;
        end else if (avs_read && !ack_q) begin
            unique case (idx)
                sac_pkg::IDX_WAKE:
                    rdata_q <= {27'h0, wake_en_q, 4'h0};
                sac_pkg::IDX_FLAGS:
                    rdata_q <= {27'h0, flag_q, 4'h0};
                sac_pkg::IDX_MASK:
                    rdata_q <= {27'h0, irq_en_q, 4'h0};
                sac_pkg::IDX_CTRL:
                    rdata_q <= {24'h0, ctrl_q[7:5], go_q, ctrl_q[3:0]};
                sac_pkg::IDX_REF: rdata_q <= {24'h0, ref_q};
                sac_pkg::IDX_CHAN: rdata_q <= {24'h0, chan_q};
                sac_pkg::IDX_PINL: rdata_q <= {24'h0, pinl_q};
                sac_pkg::IDX_PINH: rdata_q <= {24'h0, pinh_q};
                sac_pkg::IDX_RESL: rdata_q <= {24'h0, resl_q};
                sac_pkg::IDX_RESH: rdata_q <= {24'h0, resh_q};
                sac_pkg::IDX_AUXL: rdata_q <= {24'h0, auxl_q};
                sac_pkg::IDX_AUXH: rdata_q <= {24'h0, auxh_q};
                // Unmapped addresses read as zero
                default: rdata_q <= 32'h0000_0000;
            endcase
        end
    end

    assign avs_readdata = rdata_q;

    // Control register writes
    assign wr_ctrl = hit(wr_ok, idx, sac_pkg::IDX_CTRL);
    assign wd_go = wd[sac_pkg::CTRL_GO_BIT];
    assign wd_pwr = wd[sac_pkg::CTRL_PWR_BIT];

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            ctrl_q <= sac_pkg::RST_VAL;
        end else if (wr_ctrl) begin
            ctrl_q <= wd;
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            ref_q <= sac_pkg::RST_VAL;
        end else if (hit(wr_ok, idx, sac_pkg::IDX_REF)) begin
            ref_q <= wd & sac_pkg::REF_MASK;
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            chan_q <= sac_pkg::RST_VAL;
        end else if (hit(wr_ok, idx, sac_pkg::IDX_CHAN)) begin
            chan_q <= wd & sac_pkg::CHAN_MASK;
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            pinl_q <= sac_pkg::RST_VAL;
            pinh_q <= sac_pkg::RST_VAL;
        end else begin
            if (hit(wr_ok, idx, sac_pkg::IDX_PINL)) begin
                pinl_q <= wd;
            end
            if (hit(wr_ok, idx, sac_pkg::IDX_PINH)) begin
                pinh_q <= wd & sac_pkg::PINH_MASK;
            end
        end
    end

    // Spare value pair, plain storage for software
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            auxl_q <= sac_pkg::RST_VAL;
            auxh_q <= sac_pkg::RST_VAL;
        end else begin
            if (hit(wr_ok, idx, sac_pkg::IDX_AUXL)) begin
                auxl_q <= wd;
            end
            if (hit(wr_ok, idx, sac_pkg::IDX_AUXH)) begin
                auxh_q <= wd;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            wake_en_q <= 1'b0;
            irq_en_q <= 1'b0;
        end else begin
            if (hit(wr_ok, idx, sac_pkg::IDX_WAKE)) begin
                wake_en_q <= wd[sac_pkg::EVT_BIT];
            end
            if (hit(wr_ok, idx, sac_pkg::IDX_MASK)) begin
                irq_en_q <= wd[sac_pkg::EVT_BIT];
            end
        end
    end

    // a one written to run while idle and powered starts
    assign start = wr_ctrl & wd_go & wd_pwr & ~go_q;
    // Clearing run or power mid-conversion abandons it
    assign abort = go_q & wr_ctrl & ~(wd_go & wd_pwr);

    // run bit falls when the code is complete
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            go_q <= 1'b0;
        end else if (done) begin
            go_q <= 1'b0;
        end else if (wr_ctrl) begin
            go_q <= wd_go & wd_pwr;
        end
    end

    // ratio periods counted from the run write, sub clock ticks run free
    sac_prescaler u_prescaler (
        .ref_clk(ref_clk),
        .reset(reset),
        .restart(start),
        .div_sel(ctrl_q[sac_pkg::CTRL_CLK_LSB +: 3]),
        .green_mode(green_mode),
        .sub_clk_tick(sub_clk_tick),
        .tad_tick(tad_tick)
    );

    // sequencing never looks at the sleep state
    sac_sar_seq u_seq (
        .ref_clk(ref_clk),
        .reset(reset),
        .start(start),
        .abort(abort),
        .tad_tick(tad_tick),
        .sample_sel(ctrl_q[sac_pkg::CTRL_SHS_LSB +: 2]),
        .cmp_high(cmp_high),
        .sample_hold(sample_hold),
        .busy(seq_busy),
        .done(done),
        .code(code)
    );

    // upper four bits high, lower eight low
    // a new channel value clears the results
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            resl_q <= sac_pkg::RST_VAL;
            resh_q <= sac_pkg::RST_VAL;
        end else if (done) begin
            resl_q <= code[7:0];
            resh_q <= {4'h0, code[11:8]};
        end else if (hit(wr_ok, idx, sac_pkg::IDX_CHAN)
                     && (wd & sac_pkg::CHAN_MASK) != chan_q) begin
            resl_q <= sac_pkg::RST_VAL;
            resh_q <= sac_pkg::RST_VAL;
        end
    end

    // flag sets without regard to mask or global enable
    // so it is set whenever the interrupt is enabled too
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            flag_q <= 1'b0;
        end else if (done) begin
            // A completion beats a clearing write in the same cycle
            flag_q <= 1'b1;
        end else if (hit(wr_ok, idx, sac_pkg::IDX_FLAGS)) begin
            flag_q <= wd[sac_pkg::EVT_BIT];
        end
    end

    // completion in sleep without wake enable powers the converter off
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            shut_q <= 1'b0;
        end else if (done && core_sleep && !wake_en_q) begin
            shut_q <= 1'b1;
        end else if (wr_ctrl || !core_sleep) begin
            shut_q <= 1'b0;
        end
    end

    // an enabled, globally allowed request also wakes
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            wake_q <= 1'b0;
        end else begin
            wake_q <= done & core_sleep
                    & (wake_en_q | (irq_en_q & global_int_on));
        end
    end

    assign conv_wake = wake_q;
    // no vector without global enable, core resumes in line
    assign conv_irq_req = flag_q & irq_en_q;
    // vector request only with global enable
    assign conv_vector_req = flag_q & irq_en_q & global_int_on;
    assign conv_irq_vector = sac_pkg::IRQ_VECTOR;

    assign converter_power_on = ctrl_q[sac_pkg::CTRL_PWR_BIT] & ~shut_q;
    assign conv_busy = seq_busy;
    assign sar_code = code;
    assign pos_ref_pin_select = ref_q[sac_pkg::REF_PIN_BIT];
    assign internal_ref_level_select = ref_q[sac_pkg::REF_LVL_LSB +: 2];
    assign input_channel_select = chan_q[4:0];
    assign analog_pin_enables = {pinh_q[6:0], pinl_q};
    // divider draws current only on its own channel
    assign quarter_div_enable = (chan_q[4:0] == sac_pkg::QUARTER_CHAN);
endmodule

// >>> testbench/sac_top_sva.sv
// Port-level assertions for the SAR converter control block
`timescale 1ns/1ns
module sac_top_sva (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [8:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic core_sleep,
    input wire logic global_int_on,
    input wire logic sample_hold,
    input wire logic [11:0] sar_code,
    input wire logic conv_busy,
    input wire logic [4:0] input_channel_select,
    input wire logic quarter_div_enable,
    input wire logic conv_wake,
    input wire logic conv_irq_req,
    input wire logic conv_vector_req,
    input wire logic [7:0] conv_irq_vector
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);
    sequence s_req_start;
        $rose(avs_read | avs_write);
    endsequence
    sequence s_one_wait;
        avs_waitrequest ##1 !avs_waitrequest;
    endsequence
    sequence s_conv_tail;
        conv_busy [*8];
    endsequence
    AST_ONE_WAIT: assert property (s_req_start |-> s_one_wait)
        else $error("register request not answered after one wait");
    AST_IDLE_NO_WAIT: assert property (
        !(avs_read | avs_write) |-> !avs_waitrequest)
        else $error("wait raised with no request");
    AST_RES_HIGH: assert property (
        avs_read && !avs_waitrequest
        && avs_address[8:2] == sac_pkg::IDX_RESH
        |-> avs_readdata[31:4] == 28'h0)
        else $error("high result carries bits above 11");
    AST_VECTOR: assert property (
        conv_vector_req
        |-> conv_irq_req && global_int_on && conv_irq_vector == 8'h10)
        else $error("vector request without its causes");
    AST_QUARTER: assert property (
        quarter_div_enable
        == (input_channel_select == sac_pkg::QUARTER_CHAN))
        else $error("divider enable does not follow channel");
    AST_CONV_TAIL: assert property (
        $fell(sample_hold) && conv_busy |-> s_conv_tail)
        else $error("bit trials ended too early");
    AST_SAMPLE_BUSY: assert property (sample_hold |-> conv_busy)
        else $error("sampling outside a conversion");
    AST_WAKE_PULSE: assert property (
        conv_wake |-> $past(core_sleep) ##1 !conv_wake)
        else $error("wake pulse malformed or while awake");
    AST_CODE_HELD: assert property (
        $fell(conv_busy) |=> $stable(sar_code) [*3])
        else $error("final code changed after completion");
endmodule
bind sac_top sac_top_sva sac_top_sva_inst (.ref_clk(ref_clk), .reset(reset),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .core_sleep(core_sleep), .global_int_on(global_int_on),
    .sample_hold(sample_hold), .sar_code(sar_code), .conv_busy(conv_busy),
    .input_channel_select(input_channel_select),
    .quarter_div_enable(quarter_div_enable), .conv_wake(conv_wake),
    .conv_irq_req(conv_irq_req), .conv_vector_req(conv_vector_req),
    .conv_irq_vector(conv_irq_vector));

// >>> testbench/sac_top_bench.sv
// Self-checking bench for the SAR converter control block
`timescale 1ns/1ns
module sac_top_bench;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic [8:0] avs_address = 9'h000;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'hF;
    logic [31:0] avs_readdata;
    logic avs_waitrequest, sample_hold, conv_busy, converter_power_on;
    logic core_sleep = 1'b0;
    logic green_mode = 1'b0;
    logic global_int_on = 1'b0;
    logic sub_clk_tick = 1'b0;
    logic cmp_high, pos_ref_pin_select, quarter_div_enable;
    logic conv_wake, conv_irq_req, conv_vector_req;
    logic [11:0] sar_code;
    logic [11:0] vin = 12'h000;
    logic [1:0] internal_ref_level_select;
    logic [4:0] input_channel_select;
    logic [14:0] analog_pin_enables;
    logic [7:0] conv_irq_vector;
    int num_errors = 0;
    int n_checks = 0;
    int samp_cnt = 0;
    int wake_cnt = 0;
    int sub_cnt = 0;
    int divs [8] = '{16, 8, 4, 2, 64, 32, 1, 4};

    sac_top sac_top_inst (.ref_clk(ref_clk), .reset(reset),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .core_sleep(core_sleep),
        .green_mode(green_mode), .global_int_on(global_int_on),
        .sub_clk_tick(sub_clk_tick), .cmp_high(cmp_high),
        .sample_hold(sample_hold), .sar_code(sar_code),
        .conv_busy(conv_busy), .converter_power_on(converter_power_on),
        .pos_ref_pin_select(pos_ref_pin_select),
        .internal_ref_level_select(internal_ref_level_select),
        .input_channel_select(input_channel_select),
        .analog_pin_enables(analog_pin_enables),
        .quarter_div_enable(quarter_div_enable), .conv_wake(conv_wake),
        .conv_irq_req(conv_irq_req), .conv_vector_req(conv_vector_req),
        .conv_irq_vector(conv_irq_vector));

    // Ideal comparator: keeping a bit while input >= trial yields vin
    assign cmp_high = (vin >= sar_code);
    always #4 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        sub_cnt <= (sub_cnt + 1) % 4;
        sub_clk_tick <= (sub_cnt == 3);
    end
    always @(negedge ref_clk) begin
        if (sample_hold === 1'b1) samp_cnt++;
        if (conv_wake === 1'b1) wake_cnt++;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen,
                exp);
        end
    endtask

    // Entered just after a rising edge; leaves one idle edge behind
    // Wait and data are read at the edge, before it updates them
    task automatic bus(input logic wr, input logic [6:0] idx,
        input logic [7:0] wd, output logic [7:0] rd);
        avs_address <= {idx, 2'b00};
        avs_writedata <= {24'h0, wd};
        avs_write <= wr;
        avs_read <= ~wr;
        @(posedge ref_clk);
        while (avs_waitrequest !== 1'b0) begin
            @(posedge ref_clk);
        end
        rd = avs_readdata[7:0];
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic wr(input logic [6:0] idx, input logic [7:0] d);
        logic [7:0] x;
        bus(1'b1, idx, d, x);
    endtask

    task automatic rdc(input logic [6:0] idx, input logic [7:0] exp);
        logic [7:0] x;
        bus(1'b0, idx, 8'h00, x);
        check(x, exp);
    endtask

    task automatic t_regs();
        logic [6:0] ix [10];
        logic [7:0] ev [10];
        ix = '{sac_pkg::IDX_REF, sac_pkg::IDX_CHAN, sac_pkg::IDX_PINL,
            sac_pkg::IDX_PINH, sac_pkg::IDX_AUXL, sac_pkg::IDX_AUXH,
            sac_pkg::IDX_RESL, 7'h20, sac_pkg::IDX_WAKE, sac_pkg::IDX_MASK};
        ev = '{8'h3E, 8'h1F, 8'hA5, 8'h7F, 8'h5A, 8'hFF, 8'h00, 8'h00,
            8'h10, 8'h10};
        for (int i = 0; i < 9; i++) rdc(sac_pkg::IDX_CTRL + 7'(i), 8'h00);
        for (int i = 0; i < 10; i++) begin
            wr(ix[i], (i == 2) ? 8'hA5 : (i == 4) ? 8'h5A : 8'hFF);
            rdc(ix[i], ev[i]);
        end
        check(pos_ref_pin_select, 1'b1);
        check(internal_ref_level_select, 2'b11);
        check(quarter_div_enable, 1'b1);
        check(analog_pin_enables, 15'h7FA5);
        wr(sac_pkg::IDX_REF, 8'h08);
        check({pos_ref_pin_select, internal_ref_level_select}, 3'b010);
        wr(sac_pkg::IDX_CHAN, 8'h03);
        check(quarter_div_enable, 1'b0);
    endtask

    task automatic t_conv(input logic [2:0] code, input logic grn,
        input logic [11:0] v, input logic wk, input logic ie,
        input logic gie, input logic slp, input int per);
        logic [7:0] r;
        int n;
        vin <= v;
        green_mode <= grn;
        global_int_on <= gie;
        wr(sac_pkg::IDX_WAKE, {3'h0, wk, 4'h0});
        wr(sac_pkg::IDX_MASK, {3'h0, ie, 4'h0});
        wr(sac_pkg::IDX_CTRL, {code, 5'b01010});
        repeat (2 * per) @(posedge ref_clk);
        samp_cnt = 0;
        wake_cnt = 0;
        core_sleep <= slp;
        wr(sac_pkg::IDX_CTRL, {code, 5'b11010});
        n = 0;
        r = 8'h10;
        while (r[4] !== 1'b0 && n < 1000) begin
            bus(1'b0, sac_pkg::IDX_CTRL, 8'h00, r);
            n++;
        end
        repeat (2) @(posedge ref_clk);
        check(r[4], 1'b0);
        check(samp_cnt, 8 * per);
        rdc(sac_pkg::IDX_RESL, v[7:0]);
        rdc(sac_pkg::IDX_RESH, {4'h0, v[11:8]});
        rdc(sac_pkg::IDX_FLAGS, 8'h10);
        check(conv_irq_req, ie);
        check(conv_vector_req, ie & gie);
        check(wake_cnt, slp & (wk | (ie & gie)));
        if (slp & ~wk & ~(ie & gie)) check(converter_power_on, 1'b0);
        core_sleep <= 1'b0;
        wr(sac_pkg::IDX_FLAGS, 8'h00);
        rdc(sac_pkg::IDX_FLAGS, 8'h00);
        check(conv_irq_req, 1'b0);
        wr(sac_pkg::IDX_CHAN, 8'h04);
        rdc(sac_pkg::IDX_RESH, 8'h00);
        wr(sac_pkg::IDX_CHAN, 8'h03);
        repeat (2 * per) @(posedge ref_clk);
    endtask

    task automatic stop_test();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (30000) @(posedge ref_clk);
        num_errors++;
        stop_test();
    end

    initial begin
        repeat (6) @(posedge ref_clk);
        reset <= 1'b0;
        @(posedge ref_clk);
        t_regs();
        for (int c = 0; c < 8; c++) begin
            t_conv(3'(c), 1'b0, 12'hA5C ^ 12'(c), 1'b0, 1'b1, 1'b0, 1'b0,
                divs[c]);
        end
        t_conv(3'h6, 1'b0, 12'hFFF, 1'b1, 1'b1, 1'b1, 1'b1, 1);
        t_conv(3'h6, 1'b0, 12'h001, 1'b0, 1'b0, 1'b0, 1'b1, 1);
        t_conv(3'h6, 1'b1, 12'h800, 1'b0, 1'b1, 1'b1, 1'b0, 4);
        stop_test();
    end
endmodule
